// >>> dv/jtp_ctl_model.sv
module jtp_ctl_model (
  input wire logic clk_sys,
  output logic tck,
  output logic tms,
  output logic tdi
);
  timeunit 1ns;
  timeprecision 100ps;

  // Link clock rests low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One link clock period; odd offset keeps its edges off the system clock edges
  task automatic step(input logic ms, input logic di);
    @(posedge clk_sys);
    tms <= ms;
    tdi <= di;
    #32.3 tck = 1'b1;
    #32 tck = 1'b0;
    tdi = ~di; // Invert after the fall, so a stale level is not left on the line
  endtask
endmodule

// >>> dv/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import jtp_pkg::*;

  logic clk_sys, rst_b, clk_en, tap_reset_n, test_serial_out, test_serial_out_oe_b;
  logic tck, tms, tdi;
  jtp_status_t tap_status;
  int bad_count = 0;
  int samples_checked = 0;
  int seed;
  logic q[$];
  jtp_state_t fall_state = ST_TLR;
  logic [3:0] ins;
  logic [31:0] din;
  // Wire level as the far end sees it
  wire tdo_wire = test_serial_out_oe_b ? 1'bz : test_serial_out;

  always #2.5 clk_sys = ~clk_sys;

  jtp_tap_port i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
    .tap_reset_n(tap_reset_n), .test_clock_in(tck), .test_mode_select_in(tms),
    .test_serial_in(tdi), .test_serial_out(test_serial_out),
    .test_serial_out_oe_b(test_serial_out_oe_b), .tap_status(tap_status));
  jtp_ctl_model i_ctl (.clk_sys(clk_sys), .tck(tck), .tms(tms), .tdi(tdi));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic done_test(input string name);
    $display("test %s finished", name);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Pattern of mode select bits, first one lowest, with random serial data
  task automatic go(input logic [7:0] pat, input int n);
    for (int i = 0; i < n; i++) i_ctl.step(pat[i], 1'($random(seed)));
  endtask

  // Shift n bits from a shift state, pausing after bit 1, then back to idle
  task automatic scan(input int n, input logic [31:0] d, input logic [31:0] e);
    for (int k = 0; k < n; k++) begin
      q.push_back(e[k]);
      i_ctl.step(k == n - 1 || k == 1, d[k]);
      if (k == 1 && n > 2) go(8'h02, 3);
    end
    go(8'h01, 2);
    check("state", tap_status.state, ST_RTI);
  endtask

  // Outputs seen where the far end samples them, at the test clock rise
  always @(posedge tck) begin
    check("oe_b", test_serial_out_oe_b,
      fall_state inside {ST_SH_DR, ST_SH_IR} ? 1'b0 : 1'b1);
    if (test_serial_out_oe_b === 1'b0)
      check("tdo", tdo_wire, q.size() ? q.pop_front() : 1'bx);
  end
  always @(negedge tck) fall_state = tap_status.state;

  initial begin
    seed = 32'h74371965;
    clk_sys = 1'b0;
    rst_b = 1'b0;
    clk_en = 1'b1;
    tap_reset_n = 1'b1;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check("status", tap_status, {ST_TLR, IR_RESET_VAL});
    done_test("reset");
    // Identity read straight after reset, with a pause
    go(8'h02, 4);
    din = $random(seed);
    scan(32, din, ID_CODE_VAL);
    done_test("identity");
    // Identity, bypass and random instructions
    for (int i = 0; i < 4; i++) begin
      ins = (i == 0) ? IR_IDCODE : (i == 1) ? IR_BYPASS : 4'($random(seed));
      go(8'h03, 4);
      scan(4, 32'(ins), 32'(IR_CAPTURE_VAL));
      check("instr", tap_status.instr, ins);
      go(8'h01, 3);
      din = $random(seed);
      scan(8, din, (ins == IR_IDCODE) ? ID_CODE_VAL : {din[30:0], 1'b0});
    end
    done_test("instructions");
    // A rise while the enable is low is lost
    @(posedge clk_sys) clk_en <= 1'b0;
    i_ctl.step(1'b1, 1'b0);
    @(posedge clk_sys) clk_en <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check("state", tap_status.state, ST_RTI);
    done_test("enable");
    // Test reset strikes while the instruction scan drives
    go(8'h03, 4);
    repeat (4) @(posedge clk_sys);
    check("oe_b", test_serial_out_oe_b, 1'b0);
    @(posedge clk_sys) tap_reset_n <= 1'b0;
    #1;
    check("status", tap_status, {ST_TLR, IR_RESET_VAL});
    check("oe_b", test_serial_out_oe_b, 1'b1);
    fall_state = ST_TLR;
    repeat (3) @(posedge clk_sys);
    @(posedge clk_sys) tap_reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    go(8'h00, 1);
    check("state", tap_status.state, ST_RTI);
    go(8'h1F, 5);
    check("state", tap_status.state, ST_TLR);
    done_test("test reset");
    // System reset in mid-scan also restores the reset instruction
    go(8'h06, 5);
    scan(4, 32'(IR_BYPASS), 32'(IR_CAPTURE_VAL));
    check("instr", tap_status.instr, IR_BYPASS);
    go(8'h01, 3);
    repeat (4) @(posedge clk_sys);
    check("oe_b", test_serial_out_oe_b, 1'b0);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check("status", tap_status, {ST_TLR, IR_RESET_VAL});
    check("oe_b", test_serial_out_oe_b, 1'b1);
    check("tdo", test_serial_out, 1'b0);
    fall_state = ST_TLR;
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    go(8'h00, 1);
    check("state", tap_status.state, ST_RTI);
    done_test("system reset");
    check("queue", 8'(q.size()), 8'h00);
    final_report;
  end

  // Link traffic needs about 12 us
  initial begin
    #100_000;
    bad_count++;
    final_report;
  end
endmodule

// >>> src/jtp_pkg.sv
package jtp_pkg;

  // System clock and the fastest test clock the link may run at
  localparam int unsigned SYS_CLK_HZ = 200_000_000;
  localparam int unsigned TCK_MAX_HZ = 10_000_000;
  // Shortest test clock half period in system cycles, rounded down
  localparam int unsigned TCK_MIN_HALF_CYC = SYS_CLK_HZ / (2 * TCK_MAX_HZ);

  // Register widths
  localparam int IR_W = 4;
  localparam int DR_W = 32;

  // Instruction codes and capture/reset values
  localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;
  localparam logic [IR_W-1:0] IR_IDCODE = 4'h1;
  localparam logic [IR_W-1:0] IR_RESET_VAL = IR_IDCODE;
  localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 4'h1;
  // Identity value is arbitrary; bit 0 set as the scan standard expects
  localparam logic [DR_W-1:0] ID_CODE_VAL = 32'h0000_0001;
  localparam logic [DR_W-1:0] DR_RESET_VAL = 32'h0000_0000;

  // Controller states with the customary four-bit codes
  typedef enum logic [3:0] {
    ST_TLR = 4'hF,
    ST_RTI = 4'hC,
    ST_SEL_DR = 4'h7,
    ST_CAP_DR = 4'h6,
    ST_SH_DR = 4'h2,
    ST_EX1_DR = 4'h1,
    ST_PA_DR = 4'h3,
    ST_EX2_DR = 4'h0,
    ST_UPD_DR = 4'h5,
    ST_SEL_IR = 4'h4,
    ST_CAP_IR = 4'hE,
    ST_SH_IR = 4'hA,
    ST_EX1_IR = 4'h9,
    ST_PA_IR = 4'hB,
    ST_EX2_IR = 4'h8,
    ST_UPD_IR = 4'hD
  } jtp_state_t;

  // Raw test link inputs travel together
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jtp_pins_t;

  // Observable controller state
  typedef struct packed {
    jtp_state_t state;
    logic [IR_W-1:0] instr;
  } jtp_status_t;

  // One controller step for a sampled mode select
  function automatic jtp_state_t jtp_next(input jtp_state_t st, input logic tms);
    jtp_state_t ns;
    ns = ST_TLR;
    case (st)
      ST_TLR: ns = tms ? ST_TLR : ST_RTI;
      ST_RTI: ns = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: ns = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: ns = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: ns = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: ns = tms ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR: ns = tms ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: ns = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: ns = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: ns = tms ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: ns = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: ns = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: ns = tms ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR: ns = tms ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: ns = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: ns = tms ? ST_SEL_DR : ST_RTI;
      default: ns = ST_TLR;
    endcase
    return ns;
  endfunction

endpackage

// >>> src/jtp_sync.sv
module jtp_sync (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire jtp_pkg::jtp_pins_t pins_in,
  output jtp_pkg::jtp_pins_t pins_sync
);
  import jtp_pkg::*;

  jtp_pins_t meta_ff;
  jtp_pins_t sync_ff;
  jtp_pins_t nxt_meta;
  jtp_pins_t nxt_sync;

  // First stage feeds only the second stage
  always_comb begin
    nxt_meta = pins_in;
    nxt_sync = meta_ff;
  end

  // Two-stage synchroniser; all three pins see equal latency
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else if (clk_en) begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign pins_sync = sync_ff;

endmodule

// >>> src/jtp_tap_port.sv
// Operation
// - Test reset low forces controller reset immediately
// - Mode select sampled on test clock rise
// - Serial data shifted in on rise
// - Serial output changes on test clock fall
// - Mode select walks standard controller states
// - Serial output can float high impedance
module jtp_tap_port (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic tap_reset_n,
  input wire logic test_clock_in,
  input wire logic test_mode_select_in,
  input wire logic test_serial_in,
  output logic test_serial_out,
  output logic test_serial_out_oe_b,
  output jtp_pkg::jtp_status_t tap_status
);
  import jtp_pkg::*;

  jtp_pins_t pins_raw;
  jtp_pins_t pins_sync;
  logic tck_prev_ff;
  logic nxt_tck_prev;
  logic tck_rise;
  logic tck_fall;
  logic adv;
  logic fall_en;

  jtp_state_t state_ff;
  jtp_state_t nxt_state;
  logic [IR_W-1:0] ir_shift_ff;
  logic [IR_W-1:0] nxt_ir_shift;
  logic [IR_W-1:0] ir_ff;
  logic [IR_W-1:0] nxt_ir;
  logic [DR_W-1:0] dr_shift_ff;
  logic [DR_W-1:0] nxt_dr_shift;
  logic tdo_ff;
  logic nxt_tdo;
  logic oe_b_ff;
  logic nxt_oe_b;
  logic serial_src;
  logic in_shift;

  // Identity select is decoded at capture and at shift
  function automatic logic ident_sel(input logic [IR_W-1:0] code);
    return code == IR_IDCODE;
  endfunction

  // Link pins cross into the system clock here
  assign pins_raw = '{tck: test_clock_in, tms: test_mode_select_in, tdi: test_serial_in};

  jtp_sync u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .pins_in(pins_raw),
    .pins_sync(pins_sync)
  );

  // Edge finder on the synchronised test clock
  always_comb begin
    nxt_tck_prev = pins_sync.tck;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tck_prev_ff <= 1'b0;
    end else if (clk_en) begin
      tck_prev_ff <= nxt_tck_prev;
    end
  end

  // Mode select and data share the clock's latency, so they are taken
  // with the edge; 10 MHz leaves ten system cycles per half period
  assign tck_rise = pins_sync.tck & ~tck_prev_ff;
  assign tck_fall = ~pins_sync.tck & tck_prev_ff;
  assign adv = clk_en & tck_rise;
  assign fall_en = clk_en & tck_fall;

  assign in_shift = (state_ff == ST_SH_DR) || (state_ff == ST_SH_IR);

  // Serial source: instruction shifter, or bit 0 of the data chain,
  // which serves both the identity value and the one-bit bypass
  always_comb begin
    if (state_ff == ST_SH_IR) begin
      serial_src = ir_shift_ff[0];
    end else begin
      serial_src = dr_shift_ff[0];
    end
  end

  // Controller next values
  always_comb begin
    nxt_state = state_ff;
    nxt_ir_shift = ir_shift_ff;
    nxt_ir = ir_ff;
    nxt_dr_shift = dr_shift_ff;
    nxt_tdo = tdo_ff;
    nxt_oe_b = oe_b_ff;
    if (adv) begin
      nxt_state = jtp_next(state_ff, pins_sync.tms);
      case (state_ff)
        ST_TLR: begin
          nxt_ir = IR_RESET_VAL;
        end
        ST_CAP_IR: begin
          nxt_ir_shift = IR_CAPTURE_VAL;
        end
        ST_SH_IR: begin
          nxt_ir_shift = {pins_sync.tdi, ir_shift_ff[IR_W-1:1]};
        end
        ST_UPD_IR: begin
          nxt_ir = ir_shift_ff;
        end
        ST_CAP_DR: begin
          nxt_dr_shift = ident_sel(ir_ff) ? ID_CODE_VAL : DR_RESET_VAL;
        end
        ST_SH_DR: begin
          // Bypass is a one-bit chain held in bit 0
          if (ident_sel(ir_ff)) begin
            nxt_dr_shift = {pins_sync.tdi, dr_shift_ff[DR_W-1:1]};
          end else begin
            nxt_dr_shift = {dr_shift_ff[DR_W-1:1], pins_sync.tdi};
          end
        end
        default: begin
          nxt_state = jtp_next(state_ff, pins_sync.tms);
        end
      endcase
    end
    // Output moves half a test clock after the rise, safe for the far end
    if (fall_en) begin
      nxt_tdo = in_shift ? serial_src : 1'b0;
      nxt_oe_b = ~in_shift;
    end
  end

  // Test reset acts without any clock; flops take constants only.
  // Its release is not synchronised, but nothing moves without a
  // test clock edge, which follows release by far more than a cycle.
  always_ff @(posedge clk_sys or negedge tap_reset_n) begin
    if (!tap_reset_n) begin
      state_ff <= ST_TLR;
      ir_shift_ff <= IR_CAPTURE_VAL;
      ir_ff <= IR_RESET_VAL;
      dr_shift_ff <= DR_RESET_VAL;
      tdo_ff <= 1'b0;
      oe_b_ff <= 1'b1;
    end else if (!rst_b) begin
      state_ff <= ST_TLR;
      ir_shift_ff <= IR_CAPTURE_VAL;
      ir_ff <= IR_RESET_VAL;
      dr_shift_ff <= DR_RESET_VAL;
      tdo_ff <= 1'b0;
      oe_b_ff <= 1'b1;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      ir_shift_ff <= nxt_ir_shift;
      ir_ff <= nxt_ir;
      dr_shift_ff <= nxt_dr_shift;
      tdo_ff <= nxt_tdo;
      oe_b_ff <= nxt_oe_b;
    end
  end

  assign test_serial_out = tdo_ff;
  assign test_serial_out_oe_b = oe_b_ff;
  assign tap_status = '{state: state_ff, instr: ir_ff};

  // Checks
  jtp_state_t exp_state;
  assign exp_state = jtp_next(state_ff, pins_sync.tms);

  property p_tap_reset_holds;
    @(posedge clk_sys) disable iff (!rst_b)
      !tap_reset_n |-> (state_ff == ST_TLR) && oe_b_ff && (ir_ff == IR_RESET_VAL);
  endproperty
  a_tap_reset_holds: assert property (p_tap_reset_holds)
    else $error("Controller not held in reset by test reset");

  property p_step_on_rise;
    @(posedge clk_sys) disable iff (!rst_b)
      adv && tap_reset_n |=> !tap_reset_n || (state_ff == $past(exp_state));
  endproperty
  a_step_on_rise: assert property (p_step_on_rise)
    else $error("State did not follow sampled mode select");

  property p_still_without_rise;
    @(posedge clk_sys) disable iff (!rst_b)
      !adv && tap_reset_n |=> !tap_reset_n || $stable(state_ff);
  endproperty
  a_still_without_rise: assert property (p_still_without_rise)
    else $error("State moved without a test clock rise");

  property p_five_ones_reset;
    @(posedge clk_sys) disable iff (!rst_b || !tap_reset_n)
      adv && pins_sync.tms && (state_ff == ST_SEL_IR) |=> state_ff == ST_TLR;
  endproperty
  a_five_ones_reset: assert property (p_five_ones_reset)
    else $error("Mode select high from select-IR did not reach reset");

  property p_ir_shift_in;
    @(posedge clk_sys) disable iff (!rst_b)
      adv && tap_reset_n && (state_ff == ST_SH_IR)
      |=> !tap_reset_n || (ir_shift_ff[IR_W-1] == $past(pins_sync.tdi));
  endproperty
  a_ir_shift_in: assert property (p_ir_shift_in)
    else $error("Serial input not shifted into instruction register");

  property p_out_on_fall;
    @(posedge clk_sys) disable iff (!rst_b)
      tap_reset_n && $past(tap_reset_n) && $past(rst_b) && $changed(tdo_ff)
      |-> $past(fall_en);
  endproperty
  a_out_on_fall: assert property (p_out_on_fall)
    else $error("Serial output changed away from a falling edge");

  property p_float_outside_shift;
    @(posedge clk_sys) disable iff (!rst_b)
      fall_en && tap_reset_n && !in_shift |=> !tap_reset_n || oe_b_ff;
  endproperty
  a_float_outside_shift: assert property (p_float_outside_shift)
    else $error("Serial output driven outside a shift state");

  property p_drive_in_shift;
    @(posedge clk_sys) disable iff (!rst_b)
      fall_en && tap_reset_n && in_shift
      |=> !tap_reset_n || (!oe_b_ff && (tdo_ff == $past(serial_src)));
  endproperty
  a_drive_in_shift: assert property (p_drive_in_shift)
    else $error("Serial output not driven during shift");

endmodule
